// ### logic/uisp_top.sv
// Upper register set of the USB interface manager: flag ports, frame counter,
// packet/endpoint capture, linestate filter and transceiver control.
// Assumes APB slave access, synchronous inputs and one core clock.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module uisp_top #(
    parameter int ADDR_W = 8,
    parameter int FILT_W = 16
) (
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ADDR_W-1:0]              paddr,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           token_ok,
    input  wire logic                           crc16_fail,
    input  wire logic                           rx_active,
    input  wire logic                           rx_error,
    input  wire logic [uisp_pkg::NUM_FLAGS-1:0] flag_hold_select,
    input  wire logic                           flag_clear_stb,
    input  wire logic [uisp_pkg::NUM_FLAGS-1:0] flag_clear_bits,
    output logic [uisp_pkg::NUM_FLAGS-1:0]      signal_flag_set,
    output logic                                flag_out_port_a,
    output logic                                flag_out_port_b,
    output logic                                flag_out_port_c,
    output logic                                flag_out_port_d,
    input  wire logic                           pkt_valid,
    input  wire logic [3:0]                     pkt_pid,
    input  wire logic                           pkt_has_ep,
    input  wire logic [3:0]                     pkt_ep,
    output logic [4:0]                          rx_ep_port,
    output logic                                rx_ep_port_valid,
    input  wire logic                           sof_valid,
    input  wire logic [10:0]                    sof_frame,
    input  wire logic [1:0]                     linestate_raw,
    output logic [1:0]                          linestate_filt,
    input  wire logic                           suspended,
    output logic                                resume_req,
    output logic                                pulldown_off_a,
    output logic                                pulldown_off_b,
    output logic [2:0]                          transceiver_config_pins,
    output logic [31:0]                         otg_flag_mask,
    output logic [8:0]                          power_signal_word,
    output logic                                irq
);
    import uisp_pkg::*;

    initial
    begin
        if (ADDR_W < 7 || FILT_W < 16)
            $error("uisp_top: ADDR_W must be >= 7 and FILT_W >= 16");
    end

    // Reset release synchroniser
    logic [1:0] rst_sync_q;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    wire rst_sync_n = rst_sync_q[1];

    // APB slave, one wait state
    uisp_apb_e   apb_q;
    uisp_apb_e   apb_d;
    logic [31:0] rd_data;
    logic        rd_err;
    wire  [7:0]  addr8 = 8'(paddr);
    wire         access = psel && penable;
    always_comb
    begin
        case (apb_q)
            APB_IDLE: apb_d = access ? APB_ACK : APB_IDLE;
            APB_ACK:  apb_d = APB_IDLE;
            default:  apb_d = APB_IDLE;
        endcase
    end
    wire commit = access && (apb_q == APB_ACK);
    wire wr_en  = commit && pwrite;
    wire wr_pm  = wr_en && (addr8 == OFS_PORT_MASKS);
    wire wr_fr  = wr_en && (addr8 == OFS_FRAME);
    wire wr_epm = wr_en && (addr8 == OFS_EP_MARK);
    wire wr_otg = wr_en && (addr8 == OFS_OTG_MASK);
    wire wr_pw  = wr_en && (addr8 == OFS_POWER);
    wire wr_xc  = wr_en && (addr8 == OFS_XCVR_CTRL);
    wire wr_is  = wr_en && (addr8 == OFS_IRQ_STATUS);
    wire wr_im  = wr_en && (addr8 == OFS_IRQ_MASK);

    // Signal flags
    logic [NUM_FLAGS-1:0] flag_q;
    logic [NUM_FLAGS-1:0] flag_src;
    logic [NUM_FLAGS-1:0] flag_d;
    logic [1:0]           ls_filt_q;
    assign flag_src[FLG_TOKEN] = token_ok;
    assign flag_src[FLG_SE0]   = (ls_filt_q == LS_SE0);
    assign flag_src[FLG_K]     = (ls_filt_q == LS_K);
    assign flag_src[FLG_J]     = (ls_filt_q == LS_J);
    assign flag_src[FLG_CRC16] = crc16_fail;
    assign flag_src[FLG_RXACT] = rx_active;
    assign flag_src[FLG_RXERR] = rx_error;
    wire [NUM_FLAGS-1:0] clr_vec = flag_clear_stb ? flag_clear_bits : '0;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++)
        begin : g_flag
            // Set beats a simultaneous clear
            assign flag_d[gi] = flag_hold_select[gi]
                ? (flag_src[gi] || (flag_q[gi] && !clr_vec[gi]))
                : flag_src[gi];
        end
    endgenerate

    // Register state
    logic [31:0] port_mask_q;
    logic [10:0] frame_q;
    logic [3:0]  pid_q;
    logic [3:0]  ep_q;
    logic        ep_valid_q;
    logic [15:0] ep_mark_q;
    logic [31:0] otg_q;
    logic [8:0]  power_q;
    logic [31:0] xc_q;
    logic [IRQ_BITS-1:0] irq_st_q;
    logic [IRQ_BITS-1:0] irq_mask_q;

    wire [7:0] mask_a = port_mask_q[7:0];
    wire [7:0] mask_b = port_mask_q[15:8];
    wire [7:0] mask_c = port_mask_q[23:16];
    wire [7:0] mask_d = port_mask_q[31:24];
    wire [7:0] flag8  = {1'b0, flag_q};
    wire port_a_d = |(flag8 & mask_a);
    wire port_b_d = |(flag8 & mask_b);
    wire port_c_d = |(flag8 & mask_c);
    wire port_d_d = |(flag8 & mask_d);

    // Endpoint marking
    wire       ep_marked  = pkt_valid && pkt_has_ep && ep_mark_q[pkt_ep];
    wire [4:0] ep_port_d  = ep_marked ? ({1'b0, pkt_ep} | EP_MARK_OR)
                                      : {1'b0, pkt_ep};

    // Linestate filter: a change must stand 2^N cycles
    logic [1:0]        ls_cand_q;
    logic [FILT_W-1:0] filt_cnt_q;
    wire  [3:0]        log2_n   = xc_q[XC_LOG2_LO +: 4];
    wire  [FILT_W-1:0] limit_m1 = FILT_W'((17'h00001 << log2_n) - 17'h00001);
    wire  ls_restart = (linestate_raw != ls_cand_q);
    wire  ls_pending = !ls_restart && (ls_cand_q != ls_filt_q);
    wire  ls_update  = ls_pending && (filt_cnt_q == limit_m1);
    wire  [FILT_W-1:0] filt_cnt_d = (ls_restart || ls_update) ? '0
                                  : ls_pending ? filt_cnt_q + 1'b1 : filt_cnt_q;

    // Auto-resume from suspend
    wire susp_en    = xc_q[XC_SUSP_EN];
    wire res_se0    = susp_en && suspended && ls_update && (ls_cand_q == LS_SE0);
    wire res_k      = susp_en && suspended && ls_update && (ls_cand_q == LS_K);
    wire [31:0] xc_wr = wr_xc ? (pwdata & XC_WMASK) : (xc_q & XC_WMASK);
    wire [31:0] xc_d  = xc_wr | (32'(res_se0) << XC_RES_SE0)
                              | (32'(res_k) << XC_RES_K);

    // Interrupt events
    wire [IRQ_BITS-1:0] irq_ev = {sof_valid, ls_update, res_se0 || res_k, pkt_valid};
    wire [IRQ_BITS-1:0] irq_clr = wr_is ? pwdata[IRQ_BITS-1:0] : '0;
    wire [IRQ_BITS-1:0] irq_st_d = irq_ev | (irq_st_q & ~irq_clr);
    wire [IRQ_BITS-1:0] irq_mask_d = wr_im ? pwdata[IRQ_BITS-1:0] : irq_mask_q;

    // Read decode
    always_comb
    begin
        rd_err = 1'b0;
        if (addr8 == OFS_PORT_MASKS)
            rd_data = port_mask_q;
        else if (addr8 == OFS_FRAME)
            rd_data = {21'h0, frame_q};
        else if (addr8 == OFS_PID)
            rd_data = {28'h0, pid_q};
        else if (addr8 == OFS_ENDPOINT)
            rd_data = {27'h0, ep_valid_q, ep_q};
        else if (addr8 == OFS_EP_MARK)
            rd_data = {16'h0, ep_mark_q};
        else if (addr8 == OFS_OTG_MASK)
            rd_data = otg_q;
        else if (addr8 == OFS_POWER)
            rd_data = {23'h0, power_q};
        else if (addr8 == OFS_XCVR_CTRL)
            rd_data = xc_q;
        else if (addr8 == OFS_IRQ_STATUS)
            rd_data = {28'h0, irq_st_q};
        else if (addr8 == OFS_IRQ_MASK)
            rd_data = {28'h0, irq_mask_q};
        else
        begin
            rd_data = RST_ZERO;
            rd_err  = 1'b1;
        end
    end
    wire ack_d = access && (apb_q == APB_IDLE);

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            apb_q   <= APB_IDLE;
            pready  <= 1'b0;
            prdata  <= RST_ZERO;
            pslverr <= 1'b0;
        end
        else
        begin
            apb_q   <= apb_d;
            pready  <= ack_d;
            prdata  <= (ack_d && !pwrite) ? rd_data : RST_ZERO;
            pslverr <= ack_d && rd_err;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            port_mask_q <= RST_ZERO;
            otg_q       <= RST_ZERO;
            power_q     <= 9'h000;
            ep_mark_q   <= 16'h0000;
            xc_q        <= RST_ZERO;
            irq_st_q    <= '0;
            irq_mask_q  <= '0;
        end
        else
        begin
            if (wr_pm)
                port_mask_q <= pwdata;
            if (wr_otg)
                otg_q <= pwdata;
            if (wr_pw)
                power_q <= 9'(pwdata & POWER_WMASK);
            if (wr_epm)
                ep_mark_q <= 16'(pwdata & EPM_WMASK);
            xc_q       <= xc_d;
            irq_st_q   <= irq_st_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // Frame counter: a received frame number beats a software write
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            frame_q <= 11'h000;
        else if (sof_valid)
            frame_q <= sof_frame;
        else if (wr_fr)
            frame_q <= 11'(pwdata & FRAME_WMASK);
    end

    // Packet capture
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pid_q            <= 4'h0;
            ep_q             <= 4'h0;
            ep_valid_q       <= 1'b0;
            rx_ep_port       <= 5'h00;
            rx_ep_port_valid <= 1'b0;
        end
        else
        begin
            rx_ep_port_valid <= pkt_valid && pkt_has_ep;
            if (pkt_valid)
            begin
                pid_q      <= pkt_pid;
                ep_valid_q <= pkt_has_ep;
            end
            if (pkt_valid && pkt_has_ep)
            begin
                ep_q       <= pkt_ep;
                rx_ep_port <= ep_port_d;
            end
        end
    end

    // Flags, linestate and output ports
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            flag_q                  <= '0;
            ls_cand_q               <= LS_J;
            ls_filt_q               <= LS_J;
            filt_cnt_q              <= '0;
            flag_out_port_a         <= 1'b0;
            flag_out_port_b         <= 1'b0;
            flag_out_port_c         <= 1'b0;
            flag_out_port_d         <= 1'b0;
            resume_req              <= 1'b0;
            pulldown_off_a          <= 1'b0;
            pulldown_off_b          <= 1'b0;
            transceiver_config_pins <= 3'h0;
            irq                     <= 1'b0;
        end
        else
        begin
            flag_q     <= flag_d;
            ls_cand_q  <= linestate_raw;
            filt_cnt_q <= filt_cnt_d;
            if (ls_update)
                ls_filt_q <= ls_cand_q;
            flag_out_port_a <= port_a_d;
            flag_out_port_b <= port_b_d;
            flag_out_port_c <= port_c_d;
            flag_out_port_d <= port_d_d;
            resume_req      <= res_se0 || res_k;
            pulldown_off_a  <= xc_d[XC_PD_OFF];
            pulldown_off_b  <= xc_d[XC_PD_OFF];
            transceiver_config_pins <= xc_d[XC_CONF_LO +: 3];
            irq <= |(irq_st_d & irq_mask_d);
        end
    end

    assign signal_flag_set   = flag_q;
    assign linestate_filt    = ls_filt_q;
    assign otg_flag_mask     = otg_q;
    assign power_signal_word = power_q;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_marked_pkt;
        pkt_valid && pkt_has_ep && ep_mark_q[pkt_ep];
    endsequence
    sequence s_se0_resume;
        susp_en && suspended && ls_update && ls_cand_q == LS_SE0;
    endsequence

    a_port_a_or: assert property (1 |=> flag_out_port_a == $past(|(flag8 & mask_a)))
        else $error("port a not OR of masked flags");
    a_port_d_or: assert property (1 |=> flag_out_port_d == $past(|(flag8 & mask_d)))
        else $error("port d not OR of masked flags");
    a_frame_write: assert property (wr_fr && !sof_valid |=> frame_q == $past(pwdata[10:0]))
        else $error("frame write lost");
    a_pid_capture: assert property (pkt_valid |=> pid_q == $past(pkt_pid))
        else $error("pid not captured");
    a_ep_valid_bit: assert property (pkt_valid |=> ep_valid_q == $past(pkt_has_ep))
        else $error("endpoint valid wrong");
    a_ep_mark_out: assert property (s_marked_pkt |=> rx_ep_port_valid && rx_ep_port[4])
        else $error("marked endpoint lacks 0x10");
    a_pulldown_off: assert property (wr_xc |=> pulldown_off_a == $past(pwdata[XC_PD_OFF]))
        else $error("pulldown control wrong");
    a_se0_resume: assert property (s_se0_resume |=> xc_q[XC_RES_SE0] && resume_req ##1 !resume_req)
        else $error("se0 resume flag not set");
    a_k_hold: assert property (xc_q[XC_RES_K] && !wr_xc |=> xc_q[XC_RES_K])
        else $error("k resume flag dropped");
    a_filter_time: assert property (ls_filt_q != $past(ls_filt_q)
        |-> $past(filt_cnt_q) == $past(limit_m1))
        else $error("linestate propagated early");
    a_conf_pins: assert property (wr_xc |=> transceiver_config_pins == $past(pwdata[6:4]))
        else $error("config pins wrong");
    a_sticky_hold: assert property (1 |=> ($past(flag_q & flag_hold_select & ~clr_vec)
        & ~flag_q) == '0)
        else $error("sticky flag lost");
    a_reserved_zero: assert property ((xc_q & ~XC_WMASK) == RST_ZERO)
        else $error("reserved bits set");
endmodule

// ### logic/uisp_pkg.sv
// Register map, field layout and codes for the USB status/port register block.
// Assumes a 32-bit APB host and one 125 MHz core clock.
// Functional notes
// - Each flag port ORs its masked flags
// - Writable 11-bit frame counter, split 10:8/7:0
// - Capture packet identifier of every received packet
// - Keep last received endpoint number
// - Endpoint valid bit only for valid endpoint
// - Marked endpoints appear on port ORed 0x10
// - Control bit 18 disables both pulldowns
// - SE0 auto-resume sets bit 13 until cleared
// - K auto-resume sets bit 12 until cleared
// - Linestate change delayed two-power-N cycles
// - Bit 7 lets suspend controller resume
// - Bits 6:4 drive transceiver config pins
// - Flag 6 token ok; 5,4,3 linestate
// - Sticky flags hold until one written
package uisp_pkg;
    localparam int          NUM_FLAGS      = 7;
    localparam logic [7:0]  OFS_PORT_MASKS = 8'h24;
    localparam logic [7:0]  OFS_FRAME      = 8'h28;
    localparam logic [7:0]  OFS_PID        = 8'h2C;
    localparam logic [7:0]  OFS_ENDPOINT   = 8'h30;
    localparam logic [7:0]  OFS_EP_MARK    = 8'h34;
    localparam logic [7:0]  OFS_OTG_MASK   = 8'h38;
    localparam logic [7:0]  OFS_POWER      = 8'h3C;
    localparam logic [7:0]  OFS_XCVR_CTRL  = 8'h40;
    localparam logic [7:0]  OFS_IRQ_STATUS = 8'h44;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h48;
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
    // Field positions
    localparam int          FLG_TOKEN      = 6;
    localparam int          FLG_SE0        = 5;
    localparam int          FLG_K          = 4;
    localparam int          FLG_J          = 3;
    localparam int          FLG_CRC16      = 2;
    localparam int          FLG_RXACT      = 1;
    localparam int          FLG_RXERR      = 0;
    localparam int          EP_VALID_BIT   = 4;
    localparam int          XC_PD_OFF      = 18;
    localparam int          XC_RES_SE0     = 13;
    localparam int          XC_RES_K       = 12;
    localparam int          XC_LOG2_LO     = 8;
    localparam int          XC_SUSP_EN     = 7;
    localparam int          XC_CONF_LO     = 4;
    localparam logic [31:0] XC_WMASK       = 32'h0004_3FF0;
    localparam logic [31:0] POWER_WMASK    = 32'h0000_01FF;
    localparam logic [31:0] FRAME_WMASK    = 32'h0000_07FF;
    localparam logic [31:0] EPM_WMASK      = 32'h0000_FFFF;
    localparam logic [4:0]  EP_MARK_OR     = 5'h10;
    // Interrupt status bits
    localparam int          IRQ_PKT        = 0;
    localparam int          IRQ_RESUME     = 1;
    localparam int          IRQ_LINE       = 2;
    localparam int          IRQ_FRAME      = 3;
    localparam int          IRQ_BITS       = 4;
    // Linestate codes
    localparam logic [1:0]  LS_SE0         = 2'h0;
    localparam logic [1:0]  LS_J           = 2'h1;
    localparam logic [1:0]  LS_K           = 2'h2;
    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_ACK  = 1'b1
    } uisp_apb_e;
endpackage

// ### verif/uisp_xcvr_model.sv
// Transceiver-side model: linestate, received packet info, frame and flag sources.
// Assumes the bench calls its tasks from the core clock domain.
`timescale 1ns/1ns
module uisp_xcvr_model (
    input  wire logic   clock,
    output logic [1:0]  linestate_raw,
    output logic        pkt_valid,
    output logic [3:0]  pkt_pid,
    output logic        pkt_has_ep,
    output logic [3:0]  pkt_ep,
    output logic        sof_valid,
    output logic [10:0] sof_frame,
    output logic [3:0]  flag_src
);
    initial
    begin
        linestate_raw = 2'h1;
        pkt_valid     = 1'h0;
        pkt_pid       = 4'h5;
        pkt_has_ep    = 1'h0;
        pkt_ep        = 4'hA;
        sof_valid     = 1'h0;
        sof_frame     = 11'h2AA;
        flag_src      = 4'h0;
    end
    // Released packet fields show the inverse of the last value
    task automatic send_pkt(input logic [3:0] pid, input logic [3:0] ep, input logic has);
        @(posedge clock);
        pkt_valid  <= 1'h1;
        pkt_pid    <= pid;
        pkt_ep     <= ep;
        pkt_has_ep <= has;
        @(posedge clock);
        pkt_valid  <= 1'h0;
        pkt_pid    <= ~pid;
        pkt_ep     <= ~ep;
        pkt_has_ep <= ~has;
    endtask
    task automatic send_sof(input logic [10:0] f);
        @(posedge clock);
        sof_valid <= 1'h1;
        sof_frame <= f;
        @(posedge clock);
        sof_valid <= 1'h0;
        sof_frame <= ~f;
    endtask
    task automatic line(input logic [1:0] ls);
        @(posedge clock);
        linestate_raw <= ls;
    endtask
    // Order: token, crc16, rx_active, rx_error
    task automatic flags(input logic [3:0] v);
        @(posedge clock);
        flag_src <= v;
    endtask
endmodule

// ### verif/test_uisp_top.sv
// Self-checking bench for the USB status/port register block.
// Assumes the transceiver model drives the line and packet side.
`timescale 1ns/1ns
module test_uisp_top;
    import uisp_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, flag_clear_stb, suspended;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, otg_flag_mask, m;
    logic        pready, pslverr, pa, pb, pc, pd, rx_ep_port_valid, resume_req, irq, pda, pdb;
    logic [6:0]  flag_hold_select, flag_clear_bits, signal_flag_set;
    logic [4:0]  rx_ep_port;
    logic [1:0]  linestate_raw, linestate_filt;
    logic [2:0]  transceiver_config_pins;
    logic [8:0]  power_signal_word;
    logic [3:0]  flag_src, pid, ep;
    logic [3:0]  last_ep = 4'h0;
    logic        pkt_valid, pkt_has_ep, sof_valid, has;
    logic [3:0]  pkt_pid, pkt_ep;
    logic [10:0] sof_frame, f;
    logic [15:0] mk;
    logic [33:0] apq[$];
    logic [33:0] e;
    logic [4:0]  epq[$];
    int          n_mismatch = 0, check_count = 0, cycles = 0, n_res = 0, n, i;
    integer      seed = 32'he1f54306;
    logic [7:0]  ofs [8] = '{OFS_PORT_MASKS, OFS_FRAME, OFS_PID, OFS_ENDPOINT, OFS_EP_MARK,
                             OFS_OTG_MASK, OFS_POWER, OFS_XCVR_CTRL};
    logic [31:0] wm [8] = '{32'hFFFFFFFF, FRAME_WMASK, 32'h0, 32'h0, EPM_WMASK, 32'hFFFFFFFF,
                            POWER_WMASK, XC_WMASK};

    uisp_top u_uisp_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .token_ok(flag_src[3]), .crc16_fail(flag_src[2]),
        .rx_active(flag_src[1]), .rx_error(flag_src[0]), .flag_hold_select(flag_hold_select),
        .flag_clear_stb(flag_clear_stb), .flag_clear_bits(flag_clear_bits),
        .signal_flag_set(signal_flag_set), .flag_out_port_a(pa), .flag_out_port_b(pb),
        .flag_out_port_c(pc), .flag_out_port_d(pd), .pkt_valid(pkt_valid), .pkt_pid(pkt_pid),
        .pkt_has_ep(pkt_has_ep), .pkt_ep(pkt_ep), .rx_ep_port(rx_ep_port),
        .rx_ep_port_valid(rx_ep_port_valid), .sof_valid(sof_valid), .sof_frame(sof_frame),
        .linestate_raw(linestate_raw), .linestate_filt(linestate_filt),
        .suspended(suspended), .resume_req(resume_req), .pulldown_off_a(pda),
        .pulldown_off_b(pdb), .transceiver_config_pins(transceiver_config_pins),
        .otg_flag_mask(otg_flag_mask), .power_signal_word(power_signal_word), .irq(irq));
    uisp_xcvr_model u_uisp_xcvr_model (.clock(clock), .linestate_raw(linestate_raw),
        .pkt_valid(pkt_valid), .pkt_pid(pkt_pid), .pkt_has_ep(pkt_has_ep), .pkt_ep(pkt_ep),
        .sof_valid(sof_valid), .sof_frame(sof_frame), .flag_src(flag_src));

    initial
    begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer; the note of what is expected goes to the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] x);
        apq.push_back({~wr, a == 8'h50, x});
        @(posedge clock);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1)
            @(posedge clock);
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clock);
        @(negedge clock);
    endtask
    always @(posedge clock)
    begin
        if (psel && penable && pready === 1'h1 && apq.size() > 0)
        begin
            e = apq.pop_front();
            check("apb", {pslverr, e[33] ? prdata : e[31:0]}, e[32:0]);
        end
        if (rx_ep_port_valid === 1'h1 && epq.size() > 0)
            check("rx_ep_port", 33'(rx_ep_port), 33'(epq.pop_front()));
        if (resume_req === 1'h1)
            n_res++;
        cycles++;
        if (cycles > 20000)
        begin
            n_mismatch++;
            close_out;
        end
    end

    initial
    begin
        {rst_n, psel, penable, pwrite, flag_clear_stb, suspended} = 6'h0;
        {paddr, pwdata, flag_hold_select, flag_clear_bits} = 54'h0;
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        repeat (4) @(posedge clock);
        for (i = 0; i < 8; i++)
        begin
            apb(1'h0, ofs[i], 32'h0, 32'h0);
            apb(1'h1, ofs[i], 32'hFFFFFFFF, 32'hFFFFFFFF);
            apb(1'h0, ofs[i], 32'h0, wm[i]);
        end
        settle(1);
        check("pulldown", 33'({pdb, pda}), 33'h3);
        check("conf", 33'(transceiver_config_pins), 33'h7);
        check("otg", 33'(otg_flag_mask), 33'hFFFFFFFF);
        check("power", 33'(power_signal_word), 33'h1FF);
        for (i = 0; i < 8; i++)
            apb(1'h1, ofs[i], 32'h0, 32'h0);
        apb(1'h1, 8'h50, 32'hFFFFFFFF, 32'h0);
        apb(1'h0, 8'h50, 32'h0, 32'h0);
        settle(1);
        check("pulldown", 33'({pdb, pda}), 33'h0);
        f = 11'($random(seed));
        u_uisp_xcvr_model.send_sof(f);
        apb(1'h0, OFS_FRAME, 32'h0, 32'(f));
        apb(1'h1, OFS_IRQ_STATUS, 32'hF, 32'hF);
        apb(1'h0, OFS_IRQ_STATUS, 32'h0, 32'h0);
        apb(1'h1, OFS_IRQ_MASK, 32'h1, 32'h1);
        for (i = 0; i < 6; i++)
        begin
            {pid, ep, has, mk} = 25'($random(seed));
            apb(1'h1, OFS_EP_MARK, 32'(mk), 32'(mk));
            if (has)
            begin
                epq.push_back({mk[ep], ep});
                last_ep = ep;
            end
            u_uisp_xcvr_model.send_pkt(pid, ep, has);
            apb(1'h0, OFS_PID, 32'h0, 32'(pid));
            apb(1'h0, OFS_ENDPOINT, 32'h0, 32'({has, last_ep}));
        end
        check("irq", 33'(irq), 33'h1);
        apb(1'h0, OFS_IRQ_STATUS, 32'h0, 32'h1);
        apb(1'h1, OFS_IRQ_MASK, 32'h0, 32'h0);
        settle(2);
        check("irq masked", 33'(irq), 33'h0);
        apb(1'h1, OFS_IRQ_MASK, 32'h1, 32'h1);
        apb(1'h1, OFS_IRQ_STATUS, 32'h1, 32'h1);
        settle(2);
        check("irq cleared", 33'(irq), 33'h0);
        u_uisp_xcvr_model.flags(4'h2);
        settle(3);
        check("flags", 33'(signal_flag_set), 33'h0A);
        for (i = 0; i < 4; i++)
        begin
            m = $random(seed) & 32'h7F7F7F7F;
            apb(1'h1, OFS_PORT_MASKS, m, m);
            settle(2);
            check("ports", 33'({pd, pc, pb, pa}), 33'({|(m[30:24] & 7'h0A),
                |(m[22:16] & 7'h0A), |(m[14:8] & 7'h0A), |(m[6:0] & 7'h0A)}));
        end
        @(posedge clock);
        flag_hold_select <= 7'h40;
        u_uisp_xcvr_model.flags(4'hA);
        u_uisp_xcvr_model.flags(4'h2);
        settle(3);
        check("sticky", 33'(signal_flag_set), 33'h4A);
        @(posedge clock);
        flag_clear_stb  <= 1'h1;
        flag_clear_bits <= 7'h40;
        @(posedge clock);
        flag_clear_stb  <= 1'h0;
        settle(2);
        check("cleared", 33'(signal_flag_set), 33'h0A);
        apb(1'h1, OFS_XCVR_CTRL, 32'h280, 32'h280);
        suspended <= 1'h1;
        u_uisp_xcvr_model.line(LS_K);
        n = 0;
        @(negedge clock);
        while (linestate_filt !== LS_K && n < 60)
        begin
            @(negedge clock);
            n++;
        end
        check("filter delay", 33'(n), 33'((1 << 2) + 1));
        settle(3);
        apb(1'h0, OFS_XCVR_CTRL, 32'h0, 32'h1280);
        check("flags K", 33'(signal_flag_set), 33'h12);
        u_uisp_xcvr_model.line(LS_SE0);
        settle(12);
        apb(1'h0, OFS_XCVR_CTRL, 32'h0, 32'h3280);
        check("resume count", 33'(n_res), 33'h2);
        apb(1'h1, OFS_XCVR_CTRL, 32'h280, 32'h280);
        apb(1'h0, OFS_XCVR_CTRL, 32'h0, 32'h280);
        apb(1'h1, OFS_XCVR_CTRL, 32'h0, 32'h0);
        u_uisp_xcvr_model.line(LS_J);
        settle(8);
        u_uisp_xcvr_model.line(LS_K);
        settle(8);
        apb(1'h0, OFS_XCVR_CTRL, 32'h0, 32'h0);
        check("no resume", 33'(n_res), 33'h2);
        close_out;
    end
endmodule
